//--- rpmc_pkg.sv
// Package with constants and types of the reset and power mode controller.
package rpmc_pkg;
    // ------------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------------
    localparam int unsigned RPMC_OSC_PER_MCYC    = 12;
    localparam int unsigned RPMC_RST_MCYC        = 2;
    localparam int unsigned RPMC_RST_OSC_PERIODS = 24;
    // Core clock edges are oscillator edges, so the count equals periods.
    localparam int unsigned RPMC_RST_CYCLES      = RPMC_RST_OSC_PERIODS;
    localparam logic [4:0]  RPMC_RST_CNT_MAX     = 5'(RPMC_RST_CYCLES - 1);
    localparam logic [7:0]  RPMC_PORT_RESET      = 8'hFF;
    localparam logic [7:0]  RPMC_POWER_CONTROL_REG_RESET      = 8'h00;
    // Bit positions in the power control register.
    localparam int unsigned RPMC_IDL_POS         = 0;
    localparam int unsigned RPMC_PD_POS          = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPMC_RUN  = 2'b00,
        RPMC_IDLE = 2'b01,
        RPMC_PDWN = 2'b11
    } rpmc_mode_e;

    // Port latch contents of the four ports as seen from the core.
    typedef struct packed {
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } rpmc_ports_s;

    // Bus side driven by the core during normal operation.
    typedef struct packed {
        logic       addr_latch_strobe;
        logic       program_fetch_strobe;
        logic [7:0] addr_hi;
        logic       p0_bus_oe;
    } rpmc_bus_s;
endpackage

//--- rpmc_reset_qual.sv
// Reset pin synchroniser and qualifier counted in oscillator periods.
`timescale 1ns/1ps
module rpmc_reset_qual
    import rpmc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic rst_pin,
    output logic      rst_qual
);
    logic       sync1;
    logic       sync2;
    logic [4:0] cnt;

    // Two flip-flops bring the pin into the clock domain.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= rst_pin;
            sync2 <= sync1;
        end
    end

    // Count oscillator periods with the pin high, only while clocks run.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt      <= 5'h00;
            rst_qual <= 1'b0;
        end else if (!sync2) begin
            cnt      <= 5'h00;
            rst_qual <= 1'b0;
        end else if (clk_en) begin
            if (cnt == RPMC_RST_CNT_MAX) begin
                rst_qual <= 1'b1;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end
endmodule // rpmc_reset_qual

//--- rpmc_rst_src.sv
// Model of the external reset source that drives the reset pin.
`timescale 1ns/1ps
module rpmc_rst_src (
    input  wire logic core_clk,
    output logic      rst_pin
);
    // The pin starts high, as a power-on source holds it while clocks start.
    initial rst_pin = 1'b1;

    // Raises the pin just after an edge and holds it for n clock edges.
    task automatic pulse(input int unsigned n);
        @(posedge core_clk);
        rst_pin <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst_pin <= 1'b0;
    endtask
endmodule // rpmc_rst_src

//--- rpmc_top.sv
// Reset qualification and idle / power-down sequencing of the controller.
`timescale 1ns/1ps
// How it works
// - Reset pin held 24 oscillator periods while running yields full reset.
// - Oscillator passes a divide-by-two flop before internal clocking.
// - Idle stops the core clock; peripheral clock keeps running.
// - Idle begins only after the requesting instruction has finished.
// - Idle keeps core state, RAM and registers unchanged.
// - Any enabled interrupt ends idle and the core vectors to it.
// - Hardware reset during idle restarts like power-on reset.
// - Power-down stops the oscillator after the requesting instruction.
// - Power-down preserves only internal RAM contents.
// - Only hardware reset ends power-down.
// - Idle and power-down request bits live in the power control reg.
// - Idle: strobes high, port data; external memory floats p0, p2 addr.
// - Power-down: strobes low, port data; external memory floats p0.
module rpmc_top
    import rpmc_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  nrst,
    input  wire logic  rst_pin,
    input  wire logic  ext_prog_mem,
    input  wire logic  power_control_reg_wr,
    input  wire logic [7:0] power_control_reg_wdata,
    input  wire logic  instr_done,
    input  wire logic  irq_pending,
    input  wire rpmc_ports_s port_latch,
    input  wire rpmc_bus_s   core_bus,
    output logic [7:0] power_control_reg,
    output logic       half_clk,
    output logic       core_clk_en,
    output logic       periph_clk_en,
    output logic       osc_enable,
    output logic       sys_reset,
    output logic       ram_retain_only,
    output logic       irq_vector_req,
    output logic       addr_latch_strobe,
    output logic       program_fetch_strobe,
    output rpmc_ports_s port_out,
    output logic [3:0] port_oe,
    output rpmc_mode_e mode
);
    // ------------------------------------------------------------------
    // Clock divider and reset qualification
    // ------------------------------------------------------------------
    logic rst_qual;
    logic idle_req;
    logic pd_req;
    logic sys_reset_q;

    // Divide-by-two stage; oscillator duty cycle never reaches the core.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            half_clk <= 1'b0;
        end else if (osc_enable) begin
            half_clk <= ~half_clk;
        end
    end

    // Qualifier counts on every clock edge; clk_en is tied high, not to osc_enable.
    rpmc_reset_qual u_qual (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (1'b1),
        .rst_pin  (rst_pin),
        .rst_qual (rst_qual)
    );

    // Qualified reset is registered and fed to the whole system.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sys_reset   <= 1'b1;
            sys_reset_q <= 1'b1;
        end else begin
            sys_reset   <= rst_qual;
            sys_reset_q <= rst_qual;
        end
    end

    // ------------------------------------------------------------------
    // Power control register and mode machine
    // ------------------------------------------------------------------
    assign idle_req = power_control_reg[RPMC_IDL_POS];
    assign pd_req   = power_control_reg[RPMC_PD_POS];

    // Request bits are written by the core; leaving a mode clears them.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            power_control_reg <= RPMC_POWER_CONTROL_REG_RESET;
        end else if (rst_qual) begin
            power_control_reg <= RPMC_POWER_CONTROL_REG_RESET;
        end else if (power_control_reg_wr && mode == RPMC_RUN) begin
            power_control_reg <= power_control_reg_wdata;
        end else if (mode == RPMC_IDLE && irq_pending) begin
            power_control_reg[RPMC_IDL_POS] <= 1'b0;
        end
    end

    // Mode sequencing: enter after instruction end, power-down first.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode <= RPMC_RUN;
        end else if (rst_qual) begin
            mode <= RPMC_RUN;
        end else begin
            unique case (mode)
                RPMC_RUN: begin
                    if (instr_done && pd_req) begin
                        mode <= RPMC_PDWN;
                    end else if (instr_done && idle_req) begin
                        mode <= RPMC_IDLE;
                    end
                end
                RPMC_IDLE: begin
                    if (irq_pending) begin
                        mode <= RPMC_RUN;
                    end
                end
                RPMC_PDWN: begin
                    mode <= RPMC_PDWN;
                end
                default: begin
                    mode <= RPMC_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock gates, retention and interrupt hand-back
    // ------------------------------------------------------------------
    // Core clock halts in idle and power-down; peripherals stop only in
    // power-down where the oscillator itself is off.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            core_clk_en     <= 1'b0;
            periph_clk_en   <= 1'b0;
            osc_enable      <= 1'b1;
            ram_retain_only <= 1'b0;
            irq_vector_req  <= 1'b0;
        end else begin
            core_clk_en     <= mode == RPMC_RUN && !rst_qual;
            periph_clk_en   <= mode != RPMC_PDWN;
            osc_enable      <= mode != RPMC_PDWN || rst_qual;
            ram_retain_only <= mode == RPMC_PDWN;
            irq_vector_req  <= mode == RPMC_IDLE && irq_pending && !rst_qual;
        end
    end

    // ------------------------------------------------------------------
    // Pin states per mode
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr_latch_strobe    <= 1'b1;
            program_fetch_strobe <= 1'b1;
            port_out             <= {4{RPMC_PORT_RESET}};
            port_oe              <= 4'hF;
        end else begin
            unique case (mode)
                RPMC_IDLE: begin
                    addr_latch_strobe    <= 1'b1;
                    program_fetch_strobe <= 1'b1;
                    port_out             <= port_latch;
                    if (ext_prog_mem) begin
                        port_out.p2 <= core_bus.addr_hi;
                    end
                    port_oe <= {3'b111, ~ext_prog_mem};
                end
                RPMC_PDWN: begin
                    addr_latch_strobe    <= 1'b0;
                    program_fetch_strobe <= 1'b0;
                    port_out             <= port_latch;
                    port_oe              <= {3'b111, ~ext_prog_mem};
                end
                default: begin
                    addr_latch_strobe    <= core_bus.addr_latch_strobe;
                    program_fetch_strobe <= core_bus.program_fetch_strobe;
                    port_out             <= port_latch;
                    if (ext_prog_mem) begin
                        port_out.p2 <= core_bus.addr_hi;
                    end
                    port_oe <= {3'b111, core_bus.p0_bus_oe | ~ext_prog_mem};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_reset_after_hold: assert property (
        (!$rose(rst_qual) || $past(rst_pin, 3)))
        else $error("qualified reset without pin high");
    a_reset_needs_24: assert property (
        $rose(rst_qual) |-> $past(u_qual.cnt) == RPMC_RST_CNT_MAX)
        else $error("reset qualified at wrong count");
    a_idle_after_instr: assert property (
        (mode == RPMC_RUN) ##1 (mode == RPMC_IDLE) |-> $past(instr_done))
        else $error("idle entered mid instruction");
    a_pd_only_reset: assert property (
        (mode == RPMC_PDWN && !rst_qual) |=> mode == RPMC_PDWN)
        else $error("power-down left without reset");
    a_pd_wins: assert property (
        (mode == RPMC_RUN && instr_done && pd_req && idle_req && !rst_qual)
        |=> mode == RPMC_PDWN)
        else $error("idle chosen over power-down");
    a_idle_irq_exit: assert property (
        (mode == RPMC_IDLE && irq_pending && !rst_qual)
        |=> mode == RPMC_RUN && irq_vector_req)
        else $error("interrupt did not end idle");
    a_idle_strobes: assert property (
        mode == RPMC_IDLE |=> addr_latch_strobe && program_fetch_strobe
        || mode != RPMC_IDLE)
        else $error("strobes not high in idle");
    a_pd_pins: assert property (
        (mode == RPMC_PDWN ##1 mode == RPMC_PDWN) |->
        !addr_latch_strobe && !program_fetch_strobe && !osc_enable
        || rst_qual)
        else $error("power-down pins wrong");
    a_idle_core_off: assert property (
        mode == RPMC_IDLE |=> !core_clk_en && periph_clk_en)
        else $error("clocks wrong in idle");
    a_reset_ends_idle: assert property (
        (mode == RPMC_IDLE && rst_qual) |=> mode == RPMC_RUN && sys_reset)
        else $error("reset did not end idle");

    c_idle_cycle: cover property (
        mode == RPMC_IDLE ##[1:20] mode == RPMC_RUN);
    c_pd_reset: cover property (
        mode == RPMC_PDWN ##[1:100] mode == RPMC_RUN);
    c_full_reset: cover property ($rose(sys_reset_q));
endmodule // rpmc_top

//--- rpmc_top_tb_top.sv
// Self-checking testbench of the reset and power mode controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module rpmc_top_tb_top;
    import rpmc_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst, rst_pin, ext_prog_mem, power_control_reg_wr, instr_done;
    logic        irq_pending, half_clk, core_clk_en, periph_clk_en;
    logic        osc_enable, sys_reset, ram_retain_only, irq_vector_req;
    logic        addr_latch_strobe, program_fetch_strobe, h0;
    logic [7:0]  power_control_reg_wdata, power_control_reg, p2_exp;
    logic [3:0]  port_oe;
    rpmc_ports_s port_latch, port_out;
    rpmc_bus_s   core_bus;
    rpmc_mode_e  mode;
    int          n_mismatch = 0;
    int          compares = 0;

    // Clock of 25 ns period.
    always #12.5 core_clk = ~core_clk;

    rpmc_rst_src i_rpmc_rst_src (.core_clk(core_clk), .rst_pin(rst_pin));
    rpmc_top i_rpmc_top (.core_clk(core_clk), .nrst(nrst),
        .rst_pin(rst_pin), .ext_prog_mem(ext_prog_mem), .power_control_reg_wr(power_control_reg_wr),
        .power_control_reg_wdata(power_control_reg_wdata), .instr_done(instr_done),
        .irq_pending(irq_pending), .port_latch(port_latch),
        .core_bus(core_bus), .power_control_reg(power_control_reg),
        .half_clk(half_clk), .core_clk_en(core_clk_en),
        .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
        .sys_reset(sys_reset), .ram_retain_only(ram_retain_only),
        .irq_vector_req(irq_vector_req),
        .addr_latch_strobe(addr_latch_strobe),
        .program_fetch_strobe(program_fetch_strobe),
        .port_out(port_out), .port_oe(port_oe), .mode(mode));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Writes the power control register, then ends the instruction.
    task automatic enter(input logic [7:0] wd, input rpmc_mode_e m_now);
        @(posedge core_clk);
        power_control_reg_wr <= 1'b1;
        power_control_reg_wdata <= wd;
        @(posedge core_clk);
        power_control_reg_wr <= 1'b0;
        instr_done <= 1'b1;
        #1;
        `CHK("mode_early", m_now, mode)
        @(posedge core_clk);
        instr_done <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Waits a bounded time for the system reset to reach a level.
    task automatic wait_rst(input logic v);
        int k = 0;
        while (sys_reset !== v && k < 60) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        `CHK("sys_reset", v, sys_reset)
        if (sys_reset !== v) test_done();
    endtask

    // Compares strobes and port pins against the mode's pin table.
    task automatic chk_pins(input logic idle_request_bit);
        p2_exp = (idle_request_bit && ext_prog_mem) ? core_bus.addr_hi : port_latch.p2;
        `CHK("ale", idle_request_bit, addr_latch_strobe)
        `CHK("fetch", idle_request_bit, program_fetch_strobe)
        `CHK("oe", ext_prog_mem ? 4'hE : 4'hF, port_oe)
        `CHK("p1", port_latch.p1, port_out.p1)
        `CHK("p3", port_latch.p3, port_out.p3)
        `CHK("p2", p2_exp, port_out.p2)
        if (!ext_prog_mem) begin
            `CHK("p0", port_latch.p0, port_out.p0)
        end
    endtask

    // Full reset by the pin, then the register and mode are checked.
    task automatic pin_reset(input int unsigned n);
        fork
            i_rpmc_rst_src.pulse(n);
        join_none
        wait_rst(1'b1);
        `CHK("mode_rst", RPMC_RUN, mode)
        `CHK("power_control_reg_rst", RPMC_POWER_CONTROL_REG_RESET, power_control_reg)
        wait_rst(1'b0);
    endtask

    // Main sequence: power-on, then idle and power-down in each setup.
    initial begin
        {nrst, ext_prog_mem, power_control_reg_wr, instr_done, irq_pending} = '0;
        {power_control_reg_wdata, port_latch, core_bus} = '0;
        void'($urandom(32'h937D));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        // The source still holds the pin from power-on, so the first
        // qualified reset must come from the pin, not from nrst.
        @(posedge core_clk);
        #1;
        pin_reset(28);
        `CHK("power_control_reg", RPMC_POWER_CONTROL_REG_RESET, power_control_reg)
        h0 = half_clk;
        @(posedge core_clk);
        #1;
        `CHK("half_clk", ~h0, half_clk)
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            ext_prog_mem <= i[0];
            port_latch <= rpmc_ports_s'($urandom);
            core_bus <= rpmc_bus_s'(11'($urandom));
            if (i < 4) begin
                enter(8'h01, RPMC_RUN);
                `CHK("mode_idle", RPMC_IDLE, mode)
                `CHK("core_en", 1'b0, core_clk_en)
                `CHK("periph_en", 1'b1, periph_clk_en)
                chk_pins(1'b1);
                enter(8'h02, RPMC_IDLE);
                `CHK("power_control_reg_hold", 8'h01, power_control_reg)
                `CHK("mode_hold", RPMC_IDLE, mode)
                if (i < 2) begin
                    @(posedge core_clk);
                    irq_pending <= 1'b1;
                    @(posedge core_clk);
                    irq_pending <= 1'b0;
                    #1;
                    `CHK("mode_irq", RPMC_RUN, mode)
                    `CHK("idl_clr", 1'b0, power_control_reg[0])
                    `CHK("vector", 1'b1, irq_vector_req)
                    @(posedge core_clk);
                    #1;
                    `CHK("vector_end", 1'b0, irq_vector_req)
                end else begin
                    pin_reset(28);
                end
            end else begin
                enter(8'h03, RPMC_RUN);
                `CHK("mode_pd", RPMC_PDWN, mode)
                `CHK("osc_en", 1'b0, osc_enable)
                `CHK("ram_only", 1'b1, ram_retain_only)
                chk_pins(1'b0);
                @(posedge core_clk);
                irq_pending <= 1'b1;
                h0 = half_clk;
                // A pulse shorter than the qualifier needs must not wake it.
                fork
                    i_rpmc_rst_src.pulse(20);
                join_none
                repeat (30) @(posedge core_clk);
                irq_pending <= 1'b0;
                #1;
                `CHK("mode_stay", RPMC_PDWN, mode)
                `CHK("half_stop", h0, half_clk)
                pin_reset(28);
            end
        end
        test_done();
    end
endmodule // rpmc_top_tb_top
